// >>> rtl/gpr_pin_ctrl.v
`include "gpr_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module gpr_pin_ctrl
(
    // Clock and reset
    input  wire        sys_clk,
    input  wire        nrst,
    // Register port
    input  wire [15:0] reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    // Interrupt
    input  wire        irq_global_en,
    output reg         irq,
    // Pins
    input  wire [31:0] pin_in,
    output reg  [31:0] pin_out,
    output reg  [31:0] pin_oe,
    // SPI port, index 0 data in, 1 select, 2 clock, 3 data out
    input  wire [3:0]  spi_out,
    input  wire [3:0]  spi_oe,
    output reg  [3:0]  spi_in,
    // Fast serial port, index 0 tx, 1 rx, 2 rts, 3 cts
    input  wire [3:0]  fast_ser_out,
    input  wire [3:0]  fast_ser_oe,
    output wire [3:0]  fast_ser_in,
    // Host port, bits 15:0 pins 15:0, bits 21:16 pins 24:19
    input  wire [21:0] host_out,
    input  wire [21:0] host_oe,
    output wire [21:0] host_in,
    // Scan test, same layout as host port
    input  wire [21:0] scan_out,
    input  wire [21:0] scan_oe,
    output wire [21:0] scan_in
);

// ==========================================================================
// Functions
function [15:0] hi_map;
    input [15:0] v;
    begin
        hi_map = {v[15:13], 4'h0, v[8:3], 3'h0};
    end
endfunction

function mode_is;
    input [15:0] c;
    input [2:0]  code;
    begin
        mode_is = (c[`GPR_MODE_HI:`GPR_MODE_LO] == code);
    end
endfunction

// ==========================================================================
// Declarations
reg  [15:0] ctrl_q;
reg  [15:0] ctrl_d;
reg  [15:0] out_lo_q;
reg  [15:0] out_hi_q;
reg  [15:0] dir_lo_q;
reg  [15:0] dir_hi_q;
reg  [1:0]  stat_q;
reg  [1:0]  stat_d;
reg  [1:0]  mask_q;
reg  [31:0] sync1_q;
reg  [31:0] sync2_q;
reg  [31:0] sync3_q;
reg  [31:0] pin_f_q;
reg         edge_prev_q;
reg  [31:0] pin_out_d;
reg  [31:0] pin_oe_d;
reg  [15:0] rdata_d;
wire [31:0] gpio_out;
wire [31:0] gpio_oe;
wire        wr_ctrl;
wire        edge_rise;
wire        edge_fall;
wire        edge_evt;
wire        lock_evt;
wire        ssel_rr;
wire        spi_on;
wire        fast_on;
wire        host_on;
wire        scan_on;
wire [21:0] alt_out;
wire [21:0] alt_oe;
integer     k;

// ==========================================================================
// Pin synchronisers
genvar g;
generate
    for (g = 0; g < 32; g = g + 1)
    begin : g_sync
        always @(posedge sys_clk or negedge nrst)
        begin
            if (!nrst)
            begin
                sync1_q[g] <= 1'b0;
                sync2_q[g] <= 1'b0;
                sync3_q[g] <= 1'b0;
                pin_f_q[g] <= 1'b0;
            end
            else
            begin
                sync1_q[g] <= pin_in[g];
                sync2_q[g] <= sync1_q[g];
                sync3_q[g] <= sync2_q[g];
                if (sync2_q[g] == sync3_q[g])
                    pin_f_q[g] <= sync3_q[g];
            end
        end
    end
endgenerate

// ==========================================================================
// Control register write
assign wr_ctrl = reg_wr && (reg_addr == `GPR_OFS_CTRL);
assign lock_evt = wr_ctrl && ctrl_q[`GPR_BIT_LOCK]
                  && (reg_wdata[15:8] != ctrl_q[15:8]);

always @*
begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
    begin
        ctrl_d = reg_wdata & `GPR_WMASK_CTRL;
        if (ctrl_q[`GPR_BIT_LOCK])
            ctrl_d[15:8] = ctrl_q[15:8];
    end
end

// ==========================================================================
// Data, direction and control registers
always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        ctrl_q   <= `GPR_RST_CTRL;
        out_lo_q <= `GPR_RST_DATA;
        out_hi_q <= `GPR_RST_DATA;
        dir_lo_q <= `GPR_RST_DATA;
        dir_hi_q <= `GPR_RST_DATA;
        mask_q   <= `GPR_RST_EVT;
    end
    else
    begin
        ctrl_q <= ctrl_d;
        if (reg_wr)
        begin
            case (reg_addr)
                `GPR_OFS_OUT_LO: out_lo_q <= reg_wdata;
                `GPR_OFS_OUT_HI: out_hi_q <= reg_wdata & `GPR_WMASK_HI;
                `GPR_OFS_DIR_LO: dir_lo_q <= reg_wdata;
                `GPR_OFS_DIR_HI: dir_hi_q <= reg_wdata & `GPR_WMASK_HI;
                `GPR_OFS_MASK:   mask_q   <= reg_wdata[1:0];
                default:         mask_q   <= mask_q;
            endcase
        end
    end
end

// ==========================================================================
// Interrupt edge detect and status
assign edge_rise = pin_f_q[24] && !edge_prev_q;
assign edge_fall = !pin_f_q[24] && edge_prev_q;
assign edge_evt  = ctrl_q[`GPR_BIT_IEN]
                   && (ctrl_q[`GPR_BIT_POL] ? edge_rise : edge_fall);

always @*
begin
    stat_d = stat_q;
    if (reg_wr && (reg_addr == `GPR_OFS_STAT))
        stat_d = stat_q & ~reg_wdata[1:0];
    if (edge_evt)
        stat_d[`GPR_EVT_EDGE] = 1'b1;
    if (lock_evt)
        stat_d[`GPR_EVT_LOCKWR] = 1'b1;
end

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        edge_prev_q <= 1'b0;
        stat_q      <= `GPR_RST_EVT;
        irq         <= 1'b0;
    end
    else
    begin
        edge_prev_q <= pin_f_q[24];
        stat_q      <= stat_d;
        irq <= (stat_q[`GPR_EVT_EDGE] && mask_q[`GPR_EVT_EDGE]
                && ctrl_q[`GPR_BIT_IEN] && irq_global_en)
               || (stat_q[`GPR_EVT_LOCKWR] && mask_q[`GPR_EVT_LOCKWR]);
    end
end

// ==========================================================================
// Pin routing
assign gpio_out = {hi_map(out_hi_q), out_lo_q};
assign gpio_oe  = {hi_map(dir_hi_q), dir_lo_q};
assign ssel_rr  = ctrl_q[`GPR_BIT_SSEL_RR];
assign spi_on   = ctrl_q[`GPR_BIT_SPI];
assign fast_on  = ctrl_q[`GPR_BIT_FAST_SER];
assign host_on  = mode_is(ctrl_q, `GPR_MODE_HOST);
assign scan_on  = mode_is(ctrl_q, `GPR_MODE_SCAN);
assign alt_out  = scan_on ? scan_out : host_out;
assign alt_oe   = scan_on ? scan_oe : host_oe;

always @*
begin
    pin_out_d = gpio_out;
    pin_oe_d  = gpio_oe;
    if (host_on || scan_on)
    begin
        pin_out_d[15:0]  = alt_out[15:0];
        pin_oe_d[15:0]   = alt_oe[15:0];
        pin_out_d[24:19] = alt_out[21:16];
        pin_oe_d[24:19]  = alt_oe[21:16];
    end
    else
    begin
        if (fast_on)
        begin
            for (k = 0; k < 4; k = k + 1)
            begin
                pin_out_d[12+k] = fast_ser_out[k];
                pin_oe_d[12+k]  = fast_ser_oe[k];
            end
        end
        if (spi_on)
        begin
            for (k = 0; k < 4; k = k + 1)
            begin
                pin_out_d[8+k] = spi_out[k];
                pin_oe_d[8+k]  = spi_oe[k];
            end
            if (ssel_rr)
            begin
                pin_out_d[15] = spi_out[1];
                pin_oe_d[15]  = spi_oe[1];
                pin_out_d[9]  = gpio_out[9];
                pin_oe_d[9]   = gpio_oe[9];
            end
        end
    end
end

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
    begin
        pin_out <= 32'h0000_0000;
        pin_oe  <= 32'h0000_0000;
        spi_in  <= 4'h0;
    end
    else
    begin
        pin_out <= pin_out_d;
        pin_oe  <= pin_oe_d;
        spi_in  <= {pin_f_q[11:10],
                    (ssel_rr ? pin_f_q[15] : pin_f_q[9]),
                    pin_f_q[8]};
    end
end

assign fast_ser_in = pin_f_q[15:12];
assign host_in     = {pin_f_q[24:19], pin_f_q[15:0]};
assign scan_in     = {pin_f_q[24:19], pin_f_q[15:0]};

// ==========================================================================
// Register read
always @*
begin
    case (reg_addr)
        `GPR_OFS_CTRL:   rdata_d = ctrl_q;
        `GPR_OFS_OUT_LO: rdata_d = out_lo_q;
        `GPR_OFS_IN_LO:  rdata_d = pin_f_q[15:0];
        `GPR_OFS_DIR_LO: rdata_d = dir_lo_q;
        `GPR_OFS_OUT_HI: rdata_d = out_hi_q;
        `GPR_OFS_IN_HI:  rdata_d = hi_map(pin_f_q[31:16]);
        `GPR_OFS_DIR_HI: rdata_d = dir_hi_q;
        `GPR_OFS_STAT:   rdata_d = {14'h0000, stat_q};
        `GPR_OFS_MASK:   rdata_d = {14'h0000, mask_q};
        default:         rdata_d = 16'h0000;
    endcase
end

always @(posedge sys_clk or negedge nrst)
begin
    if (!nrst)
        reg_rdata <= 16'h0000;
    else if (reg_rd)
        reg_rdata <= rdata_d;
    else
        reg_rdata <= 16'h0000;
end

endmodule // gpr_pin_ctrl

`default_nettype wire

// >>> rtl/gpr_defines.vh
`ifndef GPR_DEFINES_VH
`define GPR_DEFINES_VH

// ==========================================================================
// Register offsets
`define GPR_OFS_CTRL      16'hC006
`define GPR_OFS_OUT_LO    16'hC01E
`define GPR_OFS_IN_LO     16'hC020
`define GPR_OFS_DIR_LO    16'hC022
`define GPR_OFS_OUT_HI    16'hC024
`define GPR_OFS_IN_HI     16'hC026
`define GPR_OFS_DIR_HI    16'hC028
`define GPR_OFS_STAT      16'hC0F0
`define GPR_OFS_MASK      16'hC0F2

// ==========================================================================
// Reset values
`define GPR_RST_CTRL      16'h0000
`define GPR_RST_DATA      16'h0000
`define GPR_RST_EVT       2'b00

// ==========================================================================
// Writable bits
`define GPR_WMASK_CTRL    16'h8FA3
`define GPR_WMASK_HI      16'hE1F8

// ==========================================================================
// Control field positions
`define GPR_BIT_LOCK      15
`define GPR_BIT_SSEL_RR   11
`define GPR_MODE_HI       10
`define GPR_MODE_LO       8
`define GPR_BIT_FAST_SER  7
`define GPR_BIT_SPI       5
`define GPR_BIT_POL       1
`define GPR_BIT_IEN       0

// ==========================================================================
// Mode codes
`define GPR_MODE_GPIO     3'b000
`define GPR_MODE_HOST     3'b101
`define GPR_MODE_SCAN     3'b110

// ==========================================================================
// Event bits
`define GPR_EVT_EDGE      0
`define GPR_EVT_LOCKWR    1

`endif

// >>> sim/gpr_pin_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Port checker
module gpr_pin_ctrl_checker
(
    // Clock, reset
    input wire logic        sys_clk,
    input wire logic        nrst,
    // Registers
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // Pins
    input wire logic [31:0] pin_in,
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    rd_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside read");
    absent_oe_a: assert property (
        (pin_oe & 32'h1E07_0000) == 32'h0000_0000)
        else $error("absent pin enabled");
    absent_out_a: assert property (
        (pin_out & 32'h1E07_0000) == 32'h0000_0000)
        else $error("absent pin driven");
    reset_idle_a: assert property (
        $rose(nrst) |-> pin_oe == 32'h0000_0000)
        else $error("pin enabled after reset");
    in_read_a: assert property (
        $stable(pin_in) [*6] ##0 (reg_rd && reg_addr == 16'hC020)
        |=> reg_rdata == $past(pin_in[15:0]))
        else $error("input read not pin level");
    out_back_a: assert property (
        reg_wr && reg_addr == 16'hC01E ##1 !reg_wr
        ##1 reg_rd && reg_addr == 16'hC01E
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("output readback wrong");
    hi_drive_a: assert property (
        reg_wr && reg_addr == 16'hC024 ##1 !reg_wr
        |=> pin_out[31:29] == $past(reg_wdata[15:13], 2))
        else $error("high latch not on pins");
    hi_dir_a: assert property (
        reg_wr && reg_addr == 16'hC028 ##1 !reg_wr
        |=> pin_oe[31:29] == $past(reg_wdata[15:13], 2))
        else $error("high direction not on pins");
endmodule // gpr_pin_ctrl_checker

bind gpr_pin_ctrl gpr_pin_ctrl_checker u_gpr_pin_ctrl_checker
(
    .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .pin_in, .pin_out, .pin_oe
);
`default_nettype wire

// >>> sim/gpr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// External circuits on the pins
module gpr_pin_model
(
    // From the block
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    // External drivers
    input  wire logic [31:0] ext_lvl,
    // Wire levels
    output wire logic [31:0] pin_in
);
    // Outside drives only pins the block leaves as inputs
    assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule // gpr_pin_model
`default_nettype wire

// >>> sim/test_gpr_pin_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// ======
// Bench
module test_gpr_pin_ctrl;
    logic        sys_clk, nrst, reg_wr, reg_rd, irq_global_en, irq;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, o, d, oh, dh, c;
    logic [31:0] pin_in, pin_out, pin_oe, ext_lvl, x, seed;
    logic [3:0]  spi_out, spi_oe, spi_in, fast_ser_out, fast_ser_oe;
    logic [3:0]  fast_ser_in;
    logic [21:0] host_out, host_oe, host_in, scan_out, scan_oe, scan_in;
    logic [7:0]  e, f;
    logic [21:0] ao, aw;
    logic        scn;
    int          fails, n_compared, i;
    logic [15:0] ctl_tab [8] = '{16'h0020, 16'h0820, 16'h0080, 16'h08A0,
                                 16'h0800, 16'h05A0, 16'h0600,
                                 16'h0000};

    gpr_pin_ctrl u_gpr_pin_ctrl (.sys_clk, .nrst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .irq_global_en, .irq, .pin_in,
        .pin_out, .pin_oe, .spi_out, .spi_oe, .spi_in, .fast_ser_out,
        .fast_ser_oe, .fast_ser_in, .host_out, .host_oe, .host_in,
        .scan_out, .scan_oe, .scan_in);
    gpr_pin_model u_gpr_pin_model (.pin_out, .pin_oe, .ext_lvl, .pin_in);

    function automatic logic [31:0] pins(input logic [15:0] lo, hi);
        pins = {hi[15:13], 4'h0, hi[8:3], 3'h0, lo};
    endfunction
    function automatic logic [7:0] route(input logic [15:0] cv,
        input logic [7:0] g, h, input logic [3:0] fs, s);
        route = g;
        if (cv[7])
            route[7:4] = fs;
        if (cv[5])
            route[3:0] = s;
        if (cv[5] && cv[11])
            {route[7], route[1]} = {s[1], g[1]};
        if (cv[10:8] == 3'b101 || cv[10:8] == 3'b110)
            route = h;
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [15:0] a, v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        tick(1);
        reg_wr    <= 1'b0;
        tick(1);
    endtask
    task automatic rchk(input logic [15:0] a, v);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        tick(1);
        reg_rd   <= 1'b0;
        #1 chk(32'(reg_rdata), 32'(v));
        tick(1);
    endtask
    task automatic pulse(input logic v, ex);
        ext_lvl[24] <= v;
        tick(8);
        chk(32'(irq), 32'(ex));
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        tick(20000);
        fails++;
        results();
    end
    initial
    begin
        {nrst, reg_wr, reg_rd, irq_global_en} = 4'h0;
        {reg_addr, reg_wdata, ext_lvl} = 64'h0;
        {spi_out, spi_oe, fast_ser_out, fast_ser_oe} = 16'h0;
        {host_out, host_oe, scan_out, scan_oe} = 88'h0;
        fails = 0;
        n_compared = 0;
        seed = $urandom(32'h6f66);
        tick(8);
        nrst <= 1'b1;
        tick(1);
        for (i = 0; i < 5; i++)
            rchk(16'hC01E + 16'(2 * i), 16'h0000);
        rchk(16'hC030, 16'h0000);
        repeat (10)
        begin
            {o, d, oh, dh} = {$urandom, $urandom};
            oh = oh & 16'hE1F8;
            dh = dh & 16'hE1F8;
            ext_lvl <= $urandom;
            wr(16'hC01E, o);
            rchk(16'hC01E, o);
            wr(16'hC024, oh);
            rchk(16'hC024, oh);
            wr(16'hC022, d);
            wr(16'hC028, dh);
            wr(16'hC020, ~o);
            tick(6);
            x = (pins(o, oh) & pins(d, dh)) | (ext_lvl & ~pins(d, dh));
            chk(pin_oe, pins(d, dh));
            chk(pin_out & pin_oe, pins(o, oh) & pins(d, dh));
            rchk(16'hC020, x[15:0]);
            rchk(16'hC026, {x[31:29], 4'h0, x[24:19], 3'h0});
        end
        foreach (ctl_tab[i])
        begin
            c = ctl_tab[i];
            {spi_out, spi_oe, fast_ser_out, fast_ser_oe} <= 16'($urandom);
            {host_out, host_oe, scan_out, scan_oe} <=
                88'({$urandom, $urandom, $urandom});
            wr(16'hC006, c);
            tick(6);
            scn = (c[10:8] == 3'b110);
            ao = scn ? scan_oe : host_oe;
            aw = scn ? scan_out : host_out;
            e = route(c, d[15:8], ao[15:8], fast_ser_oe, spi_oe);
            f = route(c, o[15:8], aw[15:8], fast_ser_out, spi_out);
            chk(32'(pin_oe[15:8]), 32'(e));
            chk(32'(pin_out[15:8] & e), 32'(f & e));
            if (c[10:8] == 3'b101 || scn)
                chk(32'(pin_oe[24:19]), 32'(ao[21:16]));
            x[0] = spi_oe[1] ? spi_out[1] : ext_lvl[15];
            if (c[11] && c[5])
                chk(32'(spi_in[1]), 32'(x[0]));
            chk(32'(host_in), 32'({pin_in[24:19], pin_in[15:0]}));
            chk(32'(scan_in), 32'({pin_in[24:19], pin_in[15:0]}));
            chk(32'(fast_ser_in), 32'(pin_in[15:12]));
        end
        wr(16'hC028, 16'h0000);
        wr(16'hC0F2, 16'h0001);
        irq_global_en <= 1'b1;
        for (i = 0; i < 2; i++)
        begin
            wr(16'hC006, {14'h0, i[0], 1'b1});
            pulse(~i[0], 1'b0);
            pulse(i[0], 1'b1);
            wr(16'hC0F0, 16'h0001);
            irq_global_en <= i[0];
            wr(16'hC0F2, {15'h0, ~i[0]});
            pulse(~i[0], 1'b0);
            pulse(i[0], 1'b0);
            wr(16'hC0F0, 16'h0001);
            irq_global_en <= 1'b1;
            wr(16'hC0F2, 16'h0001);
        end
        wr(16'hC006, 16'h8000);
        wr(16'hC006, 16'h0520);
        rchk(16'hC006, 16'h8020);
        results();
    end
endmodule // test_gpr_pin_ctrl
`default_nettype wire
